// >>> hdl/lsr_pkg.sv
// Constants shared by the lamp and reset-button controller.
// Assumes a single 125 MHz system clock and a 32-bit register bus.
package lsr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;  // Cycles per millisecond
  localparam int unsigned FAST_HALF_MS  = 100;   // Fast blink half period
  localparam int unsigned SLOW_HALF_MS  = 500;   // Slow blink half period
  localparam int unsigned SLOWER_HALF_MS = 1000; // Slower blink half period
  localparam int unsigned FLASH_MS      = 50;    // Short error-frame flash
  localparam int unsigned DEBOUNCE_MS   = 20;    // Button must be stable this long
  localparam int unsigned HOLD_SHORT_S  = 3;     // End of first hold interval
  localparam int unsigned HOLD_LONG_S   = 10;    // End of second hold interval
  localparam int unsigned HOLD_SHORT_MS = HOLD_SHORT_S * MS_PER_S;
  localparam int unsigned HOLD_LONG_MS  = HOLD_LONG_S * MS_PER_S;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  // Control fields
  localparam int unsigned CTRL_PWR_OK_BIT = 0;
  localparam int unsigned CTRL_NET_LSB    = 1;
  localparam logic        CTRL_PWR_OK_RST = 1'b1;

  // Status fields
  localparam int unsigned ST_PASSIVE_LSB = 0;
  localparam int unsigned ST_BUSOFF_LSB  = 4;
  localparam int unsigned ST_ADDON_LSB   = 8;
  localparam int unsigned ST_BTN_BIT     = 12;
  localparam int unsigned ST_PHASE_LSB   = 13;

  // Interrupt status fields
  localparam int unsigned IRQ_MODRST_BIT  = 0;
  localparam int unsigned IRQ_FACTORY_BIT = 1;
  localparam int unsigned IRQ_PRESS_BIT   = 2;
  localparam int unsigned IRQ_ERRFRM_LSB  = 3;
  localparam int unsigned IRQ_W           = 7;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 7'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Network-information lamp modes
  typedef enum logic [1:0] {
    LSR_NET_IDLE,
    LSR_NET_LEASE_WAIT,
    LSR_NET_READY,
    LSR_NET_CONNECTED
  } lsr_net_t;
  localparam lsr_net_t CTRL_NET_RST = LSR_NET_IDLE;

  // Button hold phases
  typedef enum logic [1:0] {
    LSR_PH_IDLE,
    LSR_PH_MODULES,
    LSR_PH_FACTORY,
    LSR_PH_CANCEL
  } lsr_phase_t;

endpackage : lsr_pkg

// >>> hdl/lsr_rate_if.sv
// Blink-rate bundle between the rate generator and the lamp logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface lsr_rate_if;
  logic ms_tick;    // One-cycle pulse every millisecond
  logic fast_sq;    // Fast square wave
  logic slow_sq;    // Slow square wave
  logic slower_sq;  // Slower square wave
  modport gen (output ms_tick, output fast_sq, output slow_sq, output slower_sq);
  modport use_rates (input ms_tick, input fast_sq, input slow_sq, input slower_sq);
endinterface : lsr_rate_if

// >>> hdl/lsr_rate_gen.sv
// Millisecond tick and three blink square waves from the system clock.
// Assumes aclk and a synchronous active-low reset.
`timescale 1ns/1ps
module lsr_rate_gen #(
  parameter int unsigned MS_CYC         = lsr_pkg::MS_CYC,
  parameter int unsigned FAST_HALF_MS   = lsr_pkg::FAST_HALF_MS,
  parameter int unsigned SLOW_HALF_MS   = lsr_pkg::SLOW_HALF_MS,
  parameter int unsigned SLOWER_HALF_MS = lsr_pkg::SLOWER_HALF_MS
) (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Rates out
  lsr_rate_if.gen     rates
);

  localparam int unsigned DW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;
  localparam int unsigned HW = 16;
  localparam int unsigned HALF [3] = '{FAST_HALF_MS, SLOW_HALF_MS, SLOWER_HALF_MS};

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MS_CYC < 1 || FAST_HALF_MS < 1 || FAST_HALF_MS >= SLOW_HALF_MS ||
      SLOW_HALF_MS >= SLOWER_HALF_MS || SLOWER_HALF_MS >= (1 << HW)) begin : g_bad
    $error("lsr_rate_gen: rates must be nonzero, rising and fit 16 bits");
  end

  logic [DW-1:0] div_r;
  logic          tick_r;
  logic [2:0]    sq_r;

  // ----------------------------------------------------------------
  // Millisecond divider
  // ----------------------------------------------------------------
  // One enable pulse per millisecond
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == DW'(MS_CYC - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Square waves, one counter per rate
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_rate
    logic [HW-1:0] cnt_r;
    // Toggle after each half period of milliseconds
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r   <= '0;
        sq_r[g] <= 1'b0;
      end else if (tick_r) begin
        if (cnt_r == HW'(HALF[g] - 1)) begin
          cnt_r   <= '0;
          sq_r[g] <= ~sq_r[g];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign rates.ms_tick   = tick_r;
  assign rates.fast_sq   = sq_r[0];
  assign rates.slow_sq   = sq_r[1];
  assign rates.slower_sq = sq_r[2];

endmodule : lsr_rate_gen

// >>> hdl/lsr_status_led_reset.sv
// Lamp driver and reset-button timer with an AXI4-Lite register slave.
// Assumes channel and add-on inputs come from logic on aclk; the
// button arrives straight from a pin and is synchronised here.
//
// Behaviour
// - Drive ten base-unit indicator lamps.
// - Power lamp steady on while unit works.
// - Lease wait: info lamp flashes fast.
// - Ready for connection: info lamp flashes slowly.
// - Host connected: info lamp steady on.
// - Passive, bus-off blink; error frame flashes red.
// - Communicating add-on: its lamp steady on.
// - Silent add-on: its lamp flashes.
// - Button press lights channel 1 red at once.
// - Release before 3 s resets all modules.
// - 3 to 10 s adds network factory reset.
// - Reset type chosen at moment of release.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module lsr_status_led_reset #(
  parameter int unsigned NCH           = 4,
  parameter int unsigned NADD          = 4,
  parameter int unsigned MS_CYC        = lsr_pkg::MS_CYC,
  parameter int unsigned DEBOUNCE_MS   = lsr_pkg::DEBOUNCE_MS,
  parameter int unsigned HOLD_SHORT_MS = lsr_pkg::HOLD_SHORT_MS,
  parameter int unsigned HOLD_LONG_MS  = lsr_pkg::HOLD_LONG_MS,
  parameter int unsigned FLASH_MS      = lsr_pkg::FLASH_MS
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Bus channel state from the controllers
  input  wire logic [NCH-1:0]   ch_err_passive,
  input  wire logic [NCH-1:0]   ch_bus_off,
  input  wire logic [NCH-1:0]   ch_err_frame,
  // Add-on link state
  input  wire logic [NADD-1:0]  addon_comm,
  // Reset button pin, low while pressed
  input  wire logic             reset_btn_n,
  // Lamps
  output logic                  power_lamp,
  output logic                  info_lamp,
  output logic [NCH-1:0]        ch_red_lamp,
  output logic [NCH-1:0]        ch_yellow_lamp,
  output logic [NADD-1:0]       addon_power_lamp,
  // Reset requests, one-cycle pulses
  output logic                  all_modules_reset,
  output logic                  net_factory_reset,
  // Interrupt
  output logic                  irq
);

  localparam int unsigned HW = $clog2(HOLD_LONG_MS + 2);
  localparam int unsigned BW = $clog2(DEBOUNCE_MS + 1);
  localparam int unsigned FW = $clog2(FLASH_MS + 1);
  localparam int unsigned IW = lsr_pkg::IRQ_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NCH < 2 || NCH > 4 || NADD > 4 || NADD < 1 || DEBOUNCE_MS < 1 ||
      FLASH_MS < 1 || HOLD_SHORT_MS < 1 || HOLD_LONG_MS <= HOLD_SHORT_MS) begin : g_bad
    $error("lsr_status_led_reset: unsupported channel count or timing");
  end

  // ----------------------------------------------------------------
  // Rate generator
  // ----------------------------------------------------------------
  lsr_rate_if rate ();

  lsr_rate_gen #(
    .MS_CYC (MS_CYC)
  ) u_rate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rates   (rate)
  );

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic                 pwr_ok_r;
  lsr_pkg::lsr_net_t    net_r;
  logic [IW-1:0]        irq_stat_r;
  logic [IW-1:0]        irq_mask_r;
  logic [IW-1:0]        irq_set;
  logic                 irq_clr;
  logic                 btn_s1_r;
  logic                 btn_s2_r;
  logic                 btn_r;
  logic [BW-1:0]        deb_r;
  logic [HW-1:0]        hold_r;
  lsr_pkg::lsr_phase_t  phase;
  logic [NCH-1:0]       flash_on;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [7:0]           awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 wr_fire;
  logic                 press_ev;
  logic                 release_ev;

  // ----------------------------------------------------------------
  // Button synchroniser and debouncer
  // ----------------------------------------------------------------
  // Two flops bring the pin onto aclk; pressed reads as 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
    end else begin
      btn_s1_r <= ~reset_btn_n;
      btn_s2_r <= btn_s1_r;
    end
  end

  // Accept a new level only after it is stable for the debounce time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_r <= 1'b0;
      deb_r <= '0;
    end else if (btn_s2_r == btn_r) begin
      deb_r <= '0;
    end else if (rate.ms_tick) begin
      if (deb_r == BW'(DEBOUNCE_MS - 1)) begin
        btn_r <= btn_s2_r;
        deb_r <= '0;
      end else begin
        deb_r <= deb_r + 1'b1;
      end
    end
  end

  assign press_ev   = btn_s2_r & ~btn_r & rate.ms_tick & (deb_r == BW'(DEBOUNCE_MS - 1));
  assign release_ev = ~btn_s2_r & btn_r & rate.ms_tick & (deb_r == BW'(DEBOUNCE_MS - 1));

  // ----------------------------------------------------------------
  // Hold timer
  // ----------------------------------------------------------------
  // Milliseconds held, saturating one past the second interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= '0;
    end else if (!btn_r) begin
      hold_r <= '0;
    end else if (rate.ms_tick && hold_r <= HW'(HOLD_LONG_MS)) begin
      hold_r <= hold_r + 1'b1;
    end
  end

  // Phase shown while held; the one in force at release is acted on
  always_comb begin
    if (!btn_r) begin
      phase = lsr_pkg::LSR_PH_IDLE;
    end else if (hold_r < HW'(HOLD_SHORT_MS)) begin
      phase = lsr_pkg::LSR_PH_MODULES;
    end else if (hold_r < HW'(HOLD_LONG_MS)) begin
      phase = lsr_pkg::LSR_PH_FACTORY;
    end else begin
      phase = lsr_pkg::LSR_PH_CANCEL;
    end
  end

  // Issue the reset chosen by the phase at the moment of release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_modules_reset <= 1'b0;
      net_factory_reset <= 1'b0;
    end else begin
      all_modules_reset <= release_ev && (phase == lsr_pkg::LSR_PH_MODULES ||
                                          phase == lsr_pkg::LSR_PH_FACTORY);
      net_factory_reset <= release_ev && phase == lsr_pkg::LSR_PH_FACTORY;
    end
  end

  // ----------------------------------------------------------------
  // Error-frame flash stretchers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_flash
    logic [FW-1:0] fcnt_r;
    // A detected error frame keeps red lit for the short flash
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fcnt_r <= '0;
      end else if (ch_err_frame[c]) begin
        fcnt_r <= FW'(FLASH_MS);
      end else if (rate.ms_tick && fcnt_r != '0) begin
        fcnt_r <= fcnt_r - 1'b1;
      end
    end
    assign flash_on[c] = (fcnt_r != '0);
  end

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  // Power lamp steady while software reports a healthy unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_lamp <= 1'b0;
    end else begin
      power_lamp <= pwr_ok_r;
    end
  end

  // Network-information lamp follows the link mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      info_lamp <= 1'b0;
    end else begin
      unique case (net_r)
        lsr_pkg::LSR_NET_IDLE:       info_lamp <= 1'b0;
        lsr_pkg::LSR_NET_LEASE_WAIT: info_lamp <= rate.fast_sq;
        lsr_pkg::LSR_NET_READY:      info_lamp <= rate.slow_sq;
        lsr_pkg::LSR_NET_CONNECTED:  info_lamp <= 1'b1;
      endcase
    end
  end

  // Channel lamps; the button pattern overrides red on channels 1 and 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_red_lamp    <= '0;
      ch_yellow_lamp <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_bus_off[c]) begin
          ch_red_lamp[c]    <= rate.slower_sq;
          ch_yellow_lamp[c] <= rate.slow_sq;
        end else if (ch_err_passive[c]) begin
          ch_red_lamp[c]    <= rate.slow_sq;
          ch_yellow_lamp[c] <= rate.slow_sq;
        end else begin
          ch_red_lamp[c]    <= flash_on[c];
          ch_yellow_lamp[c] <= 1'b0;
        end
      end
      // Channel 1 lights on the raw synchronised press, before debounce
      if (btn_s2_r && (phase == lsr_pkg::LSR_PH_IDLE || phase == lsr_pkg::LSR_PH_MODULES ||
                       phase == lsr_pkg::LSR_PH_FACTORY)) begin
        ch_red_lamp[0] <= 1'b1;
      end
      if (btn_r && phase == lsr_pkg::LSR_PH_FACTORY) begin
        ch_red_lamp[1] <= 1'b1;
      end
      if (btn_r && phase == lsr_pkg::LSR_PH_CANCEL) begin
        ch_red_lamp[0] <= 1'b0;
        ch_red_lamp[1] <= 1'b0;
      end
    end
  end

  // Add-on lamps steady when talking, flashing when silent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addon_power_lamp <= '0;
    end else begin
      for (int a = 0; a < NADD; a++) begin
        addon_power_lamp[a] <= addon_comm[a] | rate.slow_sq;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[lsr_pkg::IRQ_MODRST_BIT]  = release_ev && phase != lsr_pkg::LSR_PH_CANCEL;
    irq_set[lsr_pkg::IRQ_FACTORY_BIT] = release_ev && phase == lsr_pkg::LSR_PH_FACTORY;
    irq_set[lsr_pkg::IRQ_PRESS_BIT]   = press_ev;
    irq_set[lsr_pkg::IRQ_ERRFRM_LSB +: NCH] = ch_err_frame;
  end

  assign irq_clr = s_axi_arvalid && s_axi_arready && s_axi_araddr == lsr_pkg::ADDR_IRQ_STAT;

  // Sticky status; a read clears, a same-cycle event survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (irq_clr) begin
      irq_stat_r <= irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // Level interrupt while any unmasked bit is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  // Response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lsr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == lsr_pkg::ADDR_CTRL || awaddr_r == lsr_pkg::ADDR_IRQ_MASK ||
                       awaddr_r == lsr_pkg::ADDR_STATUS || awaddr_r == lsr_pkg::ADDR_IRQ_STAT)
                      ? lsr_pkg::RESP_OKAY : lsr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_ok_r   <= lsr_pkg::CTRL_PWR_OK_RST;
      net_r      <= lsr_pkg::CTRL_NET_RST;
      irq_mask_r <= lsr_pkg::IRQ_MASK_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      if (awaddr_r == lsr_pkg::ADDR_CTRL) begin
        pwr_ok_r <= wdata_r[lsr_pkg::CTRL_PWR_OK_BIT];
        net_r    <= lsr_pkg::lsr_net_t'(wdata_r[lsr_pkg::CTRL_NET_LSB +: 2]);
      end
      if (awaddr_r == lsr_pkg::ADDR_IRQ_MASK) begin
        irq_mask_r <= wdata_r[IW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // One read at a time; data is latched with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= lsr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= lsr_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        lsr_pkg::ADDR_CTRL: begin
          s_axi_rdata[lsr_pkg::CTRL_PWR_OK_BIT]     <= pwr_ok_r;
          s_axi_rdata[lsr_pkg::CTRL_NET_LSB +: 2]   <= net_r;
        end
        lsr_pkg::ADDR_STATUS: begin
          s_axi_rdata[lsr_pkg::ST_PASSIVE_LSB +: NCH] <= ch_err_passive;
          s_axi_rdata[lsr_pkg::ST_BUSOFF_LSB +: NCH]  <= ch_bus_off;
          s_axi_rdata[lsr_pkg::ST_ADDON_LSB +: NADD]  <= addon_comm;
          s_axi_rdata[lsr_pkg::ST_BTN_BIT]            <= btn_r;
          s_axi_rdata[lsr_pkg::ST_PHASE_LSB +: 2]     <= phase;
        end
        lsr_pkg::ADDR_IRQ_STAT: s_axi_rdata[IW-1:0] <= irq_stat_r;
        lsr_pkg::ADDR_IRQ_MASK: s_axi_rdata[IW-1:0] <= irq_mask_r;
        default:                s_axi_rresp <= lsr_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : lsr_status_led_reset

// >>> dv/lsr_operator.sv
// Operator model: presses and releases the reset button.
// Assumes the bench calls push and lift just after a rising edge.
`timescale 1ns/1ps
module lsr_operator (
  input  wire logic aclk,
  input  wire logic power_lamp,
  output logic      reset_btn_n
);
  initial reset_btn_n = 1'b1;
  // Press once the power lamp is lit, or after 100 cycles if it stays dark
  task push();
    int n;
    n = 0;
    while (!power_lamp && n < 100) begin
      @(posedge aclk);
      n++;
    end
    reset_btn_n <= 1'b0;
  endtask : push
  // Release the button at once; the bench picks the moment
  task lift();
    reset_btn_n <= 1'b1;
  endtask : lift
endmodule : lsr_operator

// >>> dv/lsr_status_led_reset_chk.sv
// Port assertions for the lamp and reset-button controller.
// Assumes it is bound to lsr_status_led_reset.
`timescale 1ns/1ps
module lsr_status_led_reset_chk (
  // Clock, reset and bus handshakes
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // Button, lamps and reset pulses
  input wire logic reset_btn_n, power_lamp, all_modules_reset, net_factory_reset, irq,
  input wire logic [3:0] ch_red_lamp, addon_comm, addon_power_lamp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_power_after_reset: assert property ($rose(aresetn) |=> power_lamp)
    else $error("power lamp not lit after reset");
  a_factory_with_all: assert property (net_factory_reset |-> all_modules_reset)
    else $error("factory reset without module reset");
  a_reset_one_cycle: assert property (all_modules_reset |=> !all_modules_reset)
    else $error("reset pulse longer than one cycle");
  a_press_ack: assert property ($fell(reset_btn_n) |-> ##[1:5] ch_red_lamp[0])
    else $error("press not acknowledged on channel 1 red");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("no read response");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_addon_steady: assert property (addon_comm[0] [*2] |-> addon_power_lamp[0])
    else $error("add-on lamp off while communicating");
  c_modules: cover property (all_modules_reset && !net_factory_reset);
  c_factory: cover property (net_factory_reset);
  c_irq: cover property (irq);
endmodule : lsr_status_led_reset_chk

// >>> dv/lsr_status_led_reset_test.sv
// Bench for the lamp and reset-button controller.
// Assumes shortened ms and hold counts; bus tasks start after an edge.
`timescale 1ns/1ps
module lsr_status_led_reset_test;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, ch_err_passive = 4'h0, ch_bus_off = 4'h0;
  logic [3:0] ch_err_frame = 4'h0, addon_comm = 4'h0, ch_red_lamp, ch_yellow_lamp;
  logic [3:0] addon_power_lamp;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reset_btn_n, power_lamp, info_lamp, all_modules_reset, net_factory_reset, irq;
  int err_count = 0, checks = 0, n, tog[13];
  int lo[13] = '{19, 0, 0, 3, 1, 0, 0, 3, 3, 0, 3, 0, 3};
  wire [12:0] probe = {addon_power_lamp, ch_yellow_lamp, ch_red_lamp, info_lamp};
  always #4 aclk = ~aclk;
  lsr_status_led_reset #(.MS_CYC(4), .DEBOUNCE_MS(2), .HOLD_SHORT_MS(10),
    .HOLD_LONG_MS(20), .FLASH_MS(3)) u_lsr_status_led_reset (.*);
  lsr_operator u_lsr_operator (.*);
  task print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task inr(input string nm, input int v, input int a, input int b);
    checks++;
    if (v < a || v > b) begin
      err_count++;
      $display("Error %s expected %0d..%0d seen %0d", nm, a, b, v);
    end
  endtask : inr
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(1);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 2'h0, s_axi_bresp);
    err_count += int'(n == 50);
    if (n == 50) print_verdict();
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(1);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
    err_count += int'(n == 50);
    if (n == 50) print_verdict();
  endtask : rd
  // Counts lamp transitions over a window
  task window(input int cyc);
    logic [12:0] prev;
    prev = probe;
    foreach (tog[i]) tog[i] = 0;
    repeat (cyc) begin
      tick(1);
      foreach (tog[i]) tog[i] += int'(probe[i] != prev[i]);
      prev = probe;
    end
  endtask : window
  task btn(input int ms, input logic [1:0] pat, input logic [1:0] rst);
    u_lsr_operator.push();
    tick(ms * 4);
    chk("red pattern", pat, ch_red_lamp[1:0]);
    u_lsr_operator.lift();
    n = 0;
    while (!all_modules_reset && n < 80) begin
      tick(1);
      n++;
    end
    chk("reset pulses", rst, {net_factory_reset, all_modules_reset});
    tick(12);
  endtask : btn
  // Main sequence
  initial begin
    tick(4);
    aresetn <= 1'b1;
    tick(3);
    chk("power_lamp", 1, power_lamp);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    ch_err_frame <= 4'h2;
    tick(1);
    ch_err_frame <= 4'h0;
    window(40);
    inr("flash", tog[2], 2, 2);
    ch_err_passive <= 4'h4;
    ch_bus_off <= 4'h8;
    addon_comm <= 4'h5;
    wr(8'h00, 32'h3);
    window(8000);
    foreach (lo[i]) inr("toggles", tog[i], lo[i], lo[i] ? lo[i] + 2 : 0);
    chk("addon on", 2'h3, {addon_power_lamp[2], addon_power_lamp[0]});
    rd(8'h04, 32'h584, 2'h0);
    wr(8'h00, 32'h5);
    window(8000);
    inr("info slow", tog[0], 3, 5);
    wr(8'h00, 32'h7);
    tick(3);
    chk("info on", 1, info_lamp);
    btn(6, 2'h1, 2'h1);
    btn(15, 2'h3, 2'h3);
    btn(30, 2'h0, 2'h0);
    rd(8'h08, 32'h17, 2'h0);
    chk("irq masked", 0, irq);
    wr(8'h0C, 32'h4);
    btn(6, 2'h1, 2'h1);
    chk("irq", 1, irq);
    rd(8'h08, 32'h5, 2'h0);
    tick(3);
    chk("irq cleared", 0, irq);
    print_verdict();
  end
  // Hang guard
  initial begin
    tick(100000);
    err_count++;
    print_verdict();
  end
endmodule : lsr_status_led_reset_test
bind lsr_status_led_reset lsr_status_led_reset_chk u_lsr_status_led_reset_chk (.*);
